// *** logic/pmt_top.sv ***
// Contract
// R1 - alert pin driven only while config bit 7 is zero; resets to one.
// R2 - config bit 6 zero enables capacitance measurement; one disables it.
// R3 - config bit 4 picks single-bit (0) or graded (1) port priority.
// R4 - bit 3 zero: class done on every write; one: only on change.
// R5 - bit 2 zero: probe done on every update; one: only on change.
// R6 - configuration register at offset 0x17, host read and write.
// R7 - trigger register at offset 0x18, write-only, resets to zero.
// R8 - trigger bits 7..4 restart class, 3..0 restart detect, paired per port.
// R9 - code 00 does nothing; 01 runs one detection and connection check.
// R10 - code 11 runs detection, check and class, without powering the port.
// R11 - host must never write code 10 for any port.
// R12 - host uses the trigger only in hand-operated style, for debug.
// R13 - in automatic styles a trigger write loads the arm bits instead.
// R14 - a trigger one is a single-cycle pulse; register keeps no state.
module pmt_top
	import pmt_pkg::*;
(
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              sys_rst,
	// two-wire serial link
	input  wire logic                              scl_in,
	input  wire logic                              sda_in,
	output logic                                   sda_out,
	output logic                                   sda_oe,
	// alert pin
	input  wire logic                              alert_req,
	output logic                                   alert_out_n,
	output logic                                   alert_oe,
	// quad configuration
	output logic                                   capacitance_probe_off,
	output logic                                   graded_priority_sel,
	// per-port state
	input  wire logic [NPORT-1:0][1:0]             port_operating_style,
	input  wire logic [NPORT-1:0]                  class_result_wr,
	input  wire logic [NPORT-1:0][RESULT_W-1:0]    port_class_result,
	input  wire logic [NPORT-1:0]                  probe_result_wr,
	input  wire logic [NPORT-1:0][RESULT_W-1:0]    port_probe_result,
	// done events
	output logic      [NPORT-1:0]                  class_finished_event,
	output logic      [NPORT-1:0]                  probe_finished_event,
	// probe requests
	output logic      [NPORT-1:0]                  probe_detect_start,
	output logic      [NPORT-1:0]                  probe_class_start,
	output logic      [NPORT-1:0]                  probe_power_inhibit,
	output logic      [NPORT-1:0]                  arm_load,
	output logic      [NPORT-1:0]                  arm_class_en,
	output logic      [NPORT-1:0]                  arm_detect_en
);

	typedef struct packed {
		logic           scl_s1;
		logic           scl_s2;
		logic           scl_s3;
		logic           sda_s1;
		logic           sda_s2;
		logic           sda_s3;
		pmt_ser_state_t state;
		logic [3:0]     bitcnt;
		logic [7:0]     shreg;
		logic           rd_mode;
		logic [7:0]     ptr;
		logic [7:0]     cfg;
		logic           trig_wr;
		logic [7:0]     trig_data;
		logic           alert_drive;
	} pmt_top_st_t;

	pmt_top_st_t st_reg;
	pmt_top_st_t st_next;

	pmt_cfg_if cfg_bus ();

	function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [7:0] cfg);
		logic [7:0] val;
		val = 8'h00;
		if (addr == REG_MISC_CFG) begin
			val = cfg & CFG_WR_MASK; // [R6]
		end
		// the trigger reads back zero: it is write-only
		return val; // [R7]
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic ser_start;
	logic ser_stop;

	// only the second and third stages feed edge and condition detection
	assign scl_rise  = st_reg.scl_s2 & ~st_reg.scl_s3;
	assign scl_fall  = ~st_reg.scl_s2 & st_reg.scl_s3;
	assign ser_start = st_reg.scl_s2 & st_reg.scl_s3 & ~st_reg.sda_s2 & st_reg.sda_s3;
	assign ser_stop  = st_reg.scl_s2 & st_reg.scl_s3 & st_reg.sda_s2 & ~st_reg.sda_s3;

	always_comb begin
		st_next = st_reg;
		st_next.scl_s1 = scl_in;
		st_next.scl_s2 = st_reg.scl_s1;
		st_next.scl_s3 = st_reg.scl_s2;
		st_next.sda_s1 = sda_in;
		st_next.sda_s2 = st_reg.sda_s1;
		st_next.sda_s3 = st_reg.sda_s2;
		st_next.trig_wr = 1'b0; // [R14]
		st_next.alert_drive = alert_req & ~st_reg.cfg[CFG_ALERT_OFF_BIT]; // [R1]

		if (ser_start) begin
			// a repeated start keeps the register pointer
			st_next.state = SER_ADDR_BYTE;
			st_next.bitcnt = 4'h0;
		end else if (ser_stop) begin
			st_next.state = SER_IDLE;
		end else begin
			unique case (st_reg.state)
				SER_IDLE: begin
				end
				SER_ADDR_BYTE, SER_PTR, SER_WDATA: begin
					if (scl_rise) begin
						st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s2};
						st_next.bitcnt = st_reg.bitcnt + 4'h1;
					end else if (scl_fall && st_reg.bitcnt == 4'h8) begin
						st_next.bitcnt = 4'h0;
						if (st_reg.state == SER_ADDR_BYTE) begin
							if (st_reg.shreg[7:1] == SER_ADDR) begin
								st_next.rd_mode = st_reg.shreg[0];
								st_next.state = SER_ACK_ADDR;
							end else begin
								st_next.state = SER_IDLE;
							end
						end else if (st_reg.state == SER_PTR) begin
							st_next.ptr = st_reg.shreg;
							st_next.state = SER_ACK_PTR;
						end else begin
							if (st_reg.ptr == REG_MISC_CFG) begin
								st_next.cfg = st_reg.shreg & CFG_WR_MASK; // [R6]
							end
							if (st_reg.ptr == REG_PROBE_TRIG) begin
								st_next.trig_wr = 1'b1; // [R7] [R14]
								st_next.trig_data = st_reg.shreg;
							end
							st_next.state = SER_ACK_WDATA;
						end
					end
				end
				SER_ACK_ADDR: begin
					if (scl_fall) begin
						if (st_reg.rd_mode) begin
							st_next.shreg = read_byte(st_reg.ptr, st_reg.cfg);
							st_next.state = SER_RDATA;
						end else begin
							st_next.state = SER_PTR;
						end
					end
				end
				SER_ACK_PTR: begin
					if (scl_fall) begin
						st_next.state = SER_WDATA;
					end
				end
				SER_ACK_WDATA: begin
					if (scl_fall) begin
						st_next.ptr = st_reg.ptr + 8'h01;
						st_next.state = SER_WDATA;
					end
				end
				SER_RDATA: begin
					if (scl_fall) begin
						if (st_reg.bitcnt == 4'h7) begin
							st_next.state = SER_RACK;
						end else begin
							st_next.shreg = {st_reg.shreg[6:0], 1'b0};
							st_next.bitcnt = st_reg.bitcnt + 4'h1;
						end
					end
				end
				SER_RACK: begin
					// host ack keeps reading, nack ends the burst
					if (scl_rise) begin
						st_next.state = st_reg.sda_s2 ? SER_IDLE : SER_RNEXT;
					end
				end
				SER_RNEXT: begin
					if (scl_fall) begin
						st_next.ptr = st_reg.ptr + 8'h01;
						st_next.shreg = read_byte(st_reg.ptr + 8'h01, st_reg.cfg);
						st_next.bitcnt = 4'h0;
						st_next.state = SER_RDATA;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '{
				scl_s1: 1'b1,
				scl_s2: 1'b1,
				scl_s3: 1'b1,
				sda_s1: 1'b1,
				sda_s2: 1'b1,
				sda_s3: 1'b1,
				state: SER_IDLE,
				bitcnt: 4'h0,
				shreg: 8'h00,
				rd_mode: 1'b0,
				ptr: 8'h00,
				cfg: MISC_CFG_RST, // [R1]
				trig_wr: 1'b0,
				trig_data: PROBE_TRIG_RST, // [R7]
				alert_drive: 1'b0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// open drain: the pins only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe  = (st_reg.state == SER_ACK_ADDR) || (st_reg.state == SER_ACK_PTR) ||
		(st_reg.state == SER_ACK_WDATA) || ((st_reg.state == SER_RDATA) && !st_reg.shreg[7]);

	assign alert_out_n = 1'b0;
	assign alert_oe    = st_reg.alert_drive; // [R1]

	assign capacitance_probe_off = st_reg.cfg[CFG_CAP_OFF_BIT]; // [R2]
	assign graded_priority_sel   = st_reg.cfg[CFG_GRADED_BIT]; // [R3]

	assign cfg_bus.cfg       = st_reg.cfg;
	assign cfg_bus.trig_wr   = st_reg.trig_wr;
	assign cfg_bus.trig_data = st_reg.trig_data;

	pmt_done_filter u_filter (
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.cfg_if               (cfg_bus.filter),
		.class_result_wr      (class_result_wr),
		.port_class_result    (port_class_result),
		.probe_result_wr      (probe_result_wr),
		.port_probe_result    (port_probe_result),
		.class_finished_event (class_finished_event),
		.probe_finished_event (probe_finished_event)
	);

	pmt_probe_launcher u_launch (
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.cfg_if               (cfg_bus.launch),
		.port_operating_style (port_operating_style),
		.probe_detect_start   (probe_detect_start),
		.probe_class_start    (probe_class_start),
		.probe_power_inhibit  (probe_power_inhibit),
		.arm_load             (arm_load),
		.arm_class_en         (arm_class_en),
		.arm_detect_en        (arm_detect_en)
	);

endmodule // pmt_top

// *** logic/pmt_pkg.sv ***
package pmt_pkg;

	localparam int NPORT = 4;

	// serial target address; arbitrary neutral value
	localparam logic [6:0] SER_ADDR = 7'h2a;

	// register offsets
	localparam logic [7:0] REG_MISC_CFG   = 8'h17;
	localparam logic [7:0] REG_PROBE_TRIG = 8'h18;

	// reset values
	localparam logic [7:0] MISC_CFG_RST   = 8'h80;
	localparam logic [7:0] PROBE_TRIG_RST = 8'h00;

	// quad_misc_config fields
	localparam int CFG_ALERT_OFF_BIT = 7;
	localparam int CFG_CAP_OFF_BIT   = 6;
	localparam int CFG_GRADED_BIT    = 4;
	localparam int CFG_CLASS_CHG_BIT = 3;
	localparam int CFG_PROBE_CHG_BIT = 2;
	// bits 5, 1 and 0 are reserved and read as zero
	localparam logic [7:0] CFG_WR_MASK = 8'hdc;

	// probe_restart_trigger fields
	localparam int TRIG_CLASS_LSB  = 4;
	localparam int TRIG_DETECT_LSB = 0;

	// restart codes {class bit, detect bit}
	localparam logic [1:0] CODE_NONE   = 2'h0;
	localparam logic [1:0] CODE_DETECT = 2'h1;
	localparam logic [1:0] CODE_BAD    = 2'h2;
	localparam logic [1:0] CODE_PROBE  = 2'h3;

	// port_operating_style encoding
	localparam logic [1:0] STYLE_SHUTDOWN       = 2'h0;
	localparam logic [1:0] STYLE_HAND           = 2'h1;
	localparam logic [1:0] STYLE_HALF_AUTOMATIC = 2'h2;
	localparam logic [1:0] STYLE_AUTOMATIC      = 2'h3;

	localparam int RESULT_W = 4;

	typedef enum logic [3:0] {
		SER_IDLE,
		SER_ADDR_BYTE,
		SER_ACK_ADDR,
		SER_PTR,
		SER_ACK_PTR,
		SER_WDATA,
		SER_ACK_WDATA,
		SER_RDATA,
		SER_RACK,
		SER_RNEXT
	} pmt_ser_state_t;

endpackage

// *** logic/pmt_cfg_if.sv ***
interface pmt_cfg_if;
	import pmt_pkg::*;

	logic [7:0] cfg;
	logic       trig_wr;
	logic [7:0] trig_data;

	modport regs (output cfg, output trig_wr, output trig_data);
	modport launch (input trig_wr, input trig_data);
	modport filter (input cfg);

endinterface

// *** logic/pmt_done_filter.sv ***
module pmt_done_filter
	import pmt_pkg::*;
(
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              sys_rst,
	// configuration
	pmt_cfg_if.filter                              cfg_if,
	// result updates from the probe engines
	input  wire logic [NPORT-1:0]                  class_result_wr,
	input  wire logic [NPORT-1:0][RESULT_W-1:0]    port_class_result,
	input  wire logic [NPORT-1:0]                  probe_result_wr,
	input  wire logic [NPORT-1:0][RESULT_W-1:0]    port_probe_result,
	// done events
	output logic      [NPORT-1:0]                  class_finished_event,
	output logic      [NPORT-1:0]                  probe_finished_event
);

	typedef struct packed {
		logic [NPORT-1:0][RESULT_W-1:0] class_prev;
		logic [NPORT-1:0][RESULT_W-1:0] probe_prev;
		logic [NPORT-1:0]               class_ev;
		logic [NPORT-1:0]               probe_ev;
	} pmt_filt_st_t;

	pmt_filt_st_t st_reg;
	pmt_filt_st_t st_next;

	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < NPORT; i++) begin
			// change mode compares against the last written value
			st_next.class_ev[i] = class_result_wr[i] &
				(~cfg_if.cfg[CFG_CLASS_CHG_BIT] |
				(port_class_result[i] != st_reg.class_prev[i])); // [R4]
			st_next.probe_ev[i] = probe_result_wr[i] &
				(~cfg_if.cfg[CFG_PROBE_CHG_BIT] |
				(port_probe_result[i] != st_reg.probe_prev[i])); // [R5]
			if (class_result_wr[i]) begin
				st_next.class_prev[i] = port_class_result[i];
			end
			if (probe_result_wr[i]) begin
				st_next.probe_prev[i] = port_probe_result[i];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign class_finished_event = st_reg.class_ev;
	assign probe_finished_event = st_reg.probe_ev;

endmodule // pmt_done_filter

// *** logic/pmt_probe_launcher.sv ***
module pmt_probe_launcher
	import pmt_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// trigger writes
	pmt_cfg_if.launch                   cfg_if,
	// port styles
	input  wire logic [NPORT-1:0][1:0]  port_operating_style,
	// one-shot probe requests
	output logic      [NPORT-1:0]       probe_detect_start,
	output logic      [NPORT-1:0]       probe_class_start,
	output logic      [NPORT-1:0]       probe_power_inhibit,
	// arm bit loads
	output logic      [NPORT-1:0]       arm_load,
	output logic      [NPORT-1:0]       arm_class_en,
	output logic      [NPORT-1:0]       arm_detect_en
);

	typedef struct packed {
		logic [NPORT-1:0] det;
		logic [NPORT-1:0] cls;
		logic [NPORT-1:0] inhibit;
		logic [NPORT-1:0] load;
		logic [NPORT-1:0] arm_cls;
		logic [NPORT-1:0] arm_det;
	} pmt_launch_st_t;

	pmt_launch_st_t st_reg;
	pmt_launch_st_t st_next;

	always_comb begin
		logic [1:0] code;
		code = CODE_NONE;
		st_next = st_reg;
		// requests are one-cycle pulses; only arm_cls and arm_det persist after the write
		st_next.det = '0; // [R14]
		st_next.cls = '0;
		st_next.inhibit = '0;
		st_next.load = '0;
		for (int i = 0; i < NPORT; i++) begin
			code = {cfg_if.trig_data[TRIG_CLASS_LSB+i], cfg_if.trig_data[TRIG_DETECT_LSB+i]}; // [R8]
			if (cfg_if.trig_wr) begin
				unique case (port_operating_style[i])
					STYLE_HAND: begin
						// code 10 is host misuse and is ignored like 00
						st_next.det[i] = (code == CODE_DETECT) | (code == CODE_PROBE); // [R9] [R11]
						st_next.cls[i] = (code == CODE_PROBE); // [R10]
						st_next.inhibit[i] = (code == CODE_PROBE); // [R10]
					end
					STYLE_HALF_AUTOMATIC, STYLE_AUTOMATIC: begin
						st_next.load[i] = 1'b1; // [R13] [R12]
						st_next.arm_cls[i] = code[1];
						st_next.arm_det[i] = code[0];
					end
					STYLE_SHUTDOWN: begin
						// a shut port takes no probe
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign probe_detect_start  = st_reg.det;
	assign probe_class_start   = st_reg.cls;
	assign probe_power_inhibit = st_reg.inhibit;
	assign arm_load            = st_reg.load;
	assign arm_class_en        = st_reg.arm_cls;
	assign arm_detect_en       = st_reg.arm_det;

endmodule // pmt_probe_launcher

// *** sim/pmt_checker.sv ***
module pmt_checker
	import pmt_pkg::*;
(
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  sys_rst,
	// pins watched
	input wire logic                  alert_req,
	input wire logic                  alert_oe,
	input wire logic [NPORT-1:0][1:0] port_operating_style,
	input wire logic [NPORT-1:0]      class_result_wr,
	input wire logic [NPORT-1:0]      probe_result_wr,
	input wire logic [NPORT-1:0]      class_finished_event,
	input wire logic [NPORT-1:0]      probe_finished_event,
	input wire logic [NPORT-1:0]      probe_detect_start,
	input wire logic [NPORT-1:0]      probe_class_start,
	input wire logic [NPORT-1:0]      probe_power_inhibit,
	input wire logic [NPORT-1:0]      arm_load
);
	logic [NPORT-1:0] hand;
	logic [NPORT-1:0] autom;
	always_comb begin
		for (int i = 0; i < NPORT; i++) begin
			hand[i] = port_operating_style[i] == STYLE_HAND;
			autom[i] = port_operating_style[i][1];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_start;
		|probe_detect_start;
	endsequence
	property p_alert;
		alert_oe |-> $past(alert_req);
	endproperty
	a_alert: assert property (p_alert) else $error("alert drive without request");
	property p_cls_evt;
		(class_finished_event & ~$past(class_result_wr)) == '0;
	endproperty
	a_cls_evt: assert property (p_cls_evt) else $error("class event without write");
	property p_prb_evt;
		(probe_finished_event & ~$past(probe_result_wr)) == '0;
	endproperty
	a_prb_evt: assert property (p_prb_evt) else $error("probe event without update");
	property p_pair;
		(probe_class_start & ~probe_detect_start) == '0;
	endproperty
	a_pair: assert property (p_pair) else $error("class start without detection");
	property p_inhibit;
		probe_power_inhibit == probe_class_start;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("power inhibit mismatch");
	property p_once;
		s_start |=> probe_detect_start == '0;
	endproperty
	a_once: assert property (p_once) else $error("start longer than a cycle");
	property p_hand;
		(probe_detect_start & ~$past(hand)) == '0;
	endproperty
	a_hand: assert property (p_hand) else $error("one-shot outside hand style");
	property p_arm;
		(arm_load & ~$past(autom)) == '0;
	endproperty
	a_arm: assert property (p_arm) else $error("arm load outside automatic");
endmodule // pmt_checker

bind pmt_top pmt_checker u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .alert_req(alert_req), .alert_oe(alert_oe),
	.port_operating_style(port_operating_style), .class_result_wr(class_result_wr),
	.probe_result_wr(probe_result_wr), .class_finished_event(class_finished_event),
	.probe_finished_event(probe_finished_event), .probe_detect_start(probe_detect_start),
	.probe_class_start(probe_class_start), .probe_power_inhibit(probe_power_inhibit),
	.arm_load(arm_load)
);

// *** sim/pmt_host_model.sv ***
module pmt_host_model
	import pmt_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// two-wire link
	input wire logic sda_line,
	output logic     scl,
	output logic     sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] addr = SER_ADDR;
	int         n_nack = 0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// five cycles a half period keeps both phases above the four-cycle minimum
	task automatic hp();
		repeat (5) @(posedge clk_sys);
		#1;
	endtask
	task automatic bitclk(output logic v);
		hp();
		scl = 1'b1;
		hp();
		v = sda_line;
		scl = 1'b0;
		// short hold so data never moves in the same cycle as the falling clock
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic start();
		sda_low = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b1;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_low = 1'b0;
		hp();
	endtask
	// ack slot is always released; only host-sent bytes count a missing ack
	task automatic xfer(input logic [7:0] b, input logic sent, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			sda_low = ~b[i];
			bitclk(r[i]);
		end
		sda_low = 1'b0;
		bitclk(a);
		if (sent && a)
			n_nack++;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({addr, 1'b0}, 1'b1, r);
		xfer(p, 1'b1, r);
		xfer(d, 1'b1, r);
		stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] r;
		start();
		xfer({addr, 1'b0}, 1'b1, r);
		xfer(p, 1'b1, r);
		start();
		xfer({addr, 1'b1}, 1'b1, r);
		xfer(8'hff, 1'b0, d);
		stop();
	endtask
endmodule // pmt_host_model

// *** sim/pse_misc_and_probe_trigger_tb_top.sv ***
module pse_misc_and_probe_trigger_tb_top;
	import pmt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0] sty;
		logic [7:0] dat;
		logic [3:0] det;
		logic [3:0] cls;
		logic [3:0] arm;
		logic [3:0] ad;
		logic [3:0] ac;
	} pmt_trig_row_t;
	logic                           clk_sys = 1'b0;
	logic                           sys_rst = 1'b1;
	logic                           alert_req = 1'b1;
	logic [NPORT-1:0][1:0]          style = '0;
	logic [NPORT-1:0]               cwr = '0;
	logic [NPORT-1:0]               pwr = '0;
	logic [NPORT-1:0][RESULT_W-1:0] cres = '0;
	logic [NPORT-1:0][RESULT_W-1:0] pres = '0;
	logic scl, sda_low, sda_oe, alert_oe, cap_off, graded;
	logic [NPORT-1:0] cev, pev, det, cls, inh, arm, arm_c, arm_d;
	logic [NPORT-1:0] det_s, cls_s, inh_s, arm_s;
	logic [7:0]       rd;
	int               n_errors = 0;
	int               n_tests = 0;
	int               det_cyc = 0;
	int               cyc = 0;
	wire              sda_line = ~(sda_low | sda_oe);
	logic [15:0] cfg_rows [5] = '{16'hffdc, 16'h4040, 16'h1010, 16'hac8c, 16'h2300};
	logic             sda_o;
	logic             alert_n;
	// one-shots only in hand style, code 10 never written
	pmt_trig_row_t trig_rows [4] = '{
		'{8'h55, 8'h4e, 4'he, 4'h4, 4'h0, 4'h0, 4'h0},
		'{8'h55, 8'h00, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0},
		'{8'h1e, 8'h2f, 4'h4, 4'h0, 4'h3, 4'h3, 4'h2},
		'{8'hfa, 8'h00, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0}};
	always #5 clk_sys = ~clk_sys;
	pmt_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_o), .sda_oe(sda_oe), .alert_req(alert_req), .alert_out_n(alert_n),
		.alert_oe(alert_oe), .capacitance_probe_off(cap_off), .graded_priority_sel(graded),
		.port_operating_style(style), .class_result_wr(cwr), .port_class_result(cres),
		.probe_result_wr(pwr), .port_probe_result(pres), .class_finished_event(cev),
		.probe_finished_event(pev), .probe_detect_start(det), .probe_class_start(cls),
		.probe_power_inhibit(inh), .arm_load(arm), .arm_class_en(arm_c),
		.arm_detect_en(arm_d));
	pmt_host_model u_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
		.sda_low(sda_low));
	task automatic conclude();
		$display("errors %0d, checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// pulses are one cycle wide, so they are gathered while the link is busy
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		det_s <= det_s | det;
		cls_s <= cls_s | cls;
		inh_s <= inh_s | inh;
		arm_s <= arm_s | arm;
		if (|det)
			det_cyc <= det_cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic res(input bit c, input int p, input logic [3:0] v, input logic exp);
		cwr[p] = c;
		pwr[p] = !c;
		cres[p] = v;
		pres[p] = v;
		@(posedge clk_sys);
		#1;
		cwr = '0;
		pwr = '0;
		chk(c ? cev[p] : pev[p], exp);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk({alert_oe, cap_off, graded}, 3'h0);
		chk({sda_o, alert_n}, 2'h0);
		u_host.rd(REG_MISC_CFG, rd);
		chk(rd, MISC_CFG_RST);
		for (int k = 0; k < 2; k++) begin
			for (int p = 0; p < NPORT; p++) begin
				res(k, p, 4'h5, 1'b1);
				res(k, p, 4'h5, 1'b1);
			end
		end
		u_host.wr(REG_MISC_CFG, 8'h08);
		res(1, 0, 4'h5, 1'b0);
		res(0, 0, 4'h5, 1'b1);
		u_host.wr(REG_MISC_CFG, 8'h04);
		res(1, 1, 4'h5, 1'b1);
		res(0, 1, 4'h5, 1'b0);
		foreach (cfg_rows[i]) begin
			u_host.wr(REG_MISC_CFG, cfg_rows[i][15:8]);
			u_host.rd(REG_MISC_CFG, rd);
			chk(rd, cfg_rows[i][7:0]);
			chk(cap_off, cfg_rows[i][6]);
			chk(graded, cfg_rows[i][4]);
			chk(alert_oe, !cfg_rows[i][7]);
		end
		foreach (trig_rows[i]) begin
			style = trig_rows[i].sty;
			{det_s, cls_s, inh_s, arm_s} = '0;
			det_cyc = 0;
			u_host.wr(REG_PROBE_TRIG, trig_rows[i].dat);
			chk(det_s, trig_rows[i].det);
			chk(cls_s, trig_rows[i].cls);
			chk(inh_s, trig_rows[i].cls);
			chk(arm_s, trig_rows[i].arm);
			chk(arm_d & arm_s, trig_rows[i].ad);
			chk(arm_c & arm_s, trig_rows[i].ac);
			chk(8'(det_cyc), 8'(trig_rows[i].det != 0));
		end
		u_host.rd(REG_PROBE_TRIG, rd);
		chk(rd, PROBE_TRIG_RST);
		u_host.wr(8'h20, 8'hff);
		u_host.addr = 7'h2b;
		u_host.wr(REG_MISC_CFG, 8'hff);
		u_host.addr = SER_ADDR;
		chk(8'(u_host.n_nack), 8'h03);
		u_host.rd(REG_MISC_CFG, rd);
		chk(rd, 8'h00);
		alert_req = 1'b0;
		@(posedge clk_sys);
		#1;
		chk(alert_oe, 1'b0);
		// a second reset in mid-run must bring back the default configuration
		sys_rst = 1'b1;
		@(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk({alert_oe, cap_off, graded}, 3'h0);
		u_host.rd(REG_MISC_CFG, rd);
		chk(rd, MISC_CFG_RST);
		conclude();
	end
endmodule // pse_misc_and_probe_trigger_tb_top
